//--- bench/p6ic_pad_model.sv
// Pad model: resolves each pin from block drive, outside drive and pull-up.
`timescale 1ns/1ps
module p6ic_pad_model (
	input  wire logic [7:0] lvl_in,   // Outside level.
	input  wire logic [7:0] drv_in,   // Outside drives the pin.
	input  wire logic [7:0] pout_in,  // Block output level.
	input  wire logic [7:0] oe_in,    // Block output enable.
	input  wire logic [7:0] pu_in,    // Pull-up switch.
	input  wire logic       clk_in,   // Clock.
	output logic      [7:0] pad_out   // Resolved level.
);
	logic [7:0] float_q = 8'h55;
	// An undriven pin without pull-up wanders so a stale level cannot pass.
	always @(posedge clk_in) float_q <= ~float_q;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe_in[i]) pad_out[i] = pout_in[i];
			else if (drv_in[i]) pad_out[i] = lvl_in[i];
			else if (pu_in[i]) pad_out[i] = 1'h1;
			else pad_out[i] = float_q[i];
		end
	end
endmodule

//--- bench/p6ic_props.sv
// Concurrent checks on the ports of the port 6 conditioning block.
`timescale 1ns/1ps
module p6ic_props (
	input wire logic       CLOCK_IN,            // Clock.
	input wire logic       RSTN_IN,             // Reset, active low.
	input wire logic       S_AXI_BVALID_OUT,    // Write response valid.
	input wire logic       S_AXI_BREADY_IN,     // Write response ready.
	input wire logic [1:0] S_AXI_BRESP_OUT,     // Write response.
	input wire logic [7:0] PIN_IN,              // Pin levels.
	input wire logic [7:0] PIN_DIRECTION_IN,    // Directions.
	input wire logic [7:0] PORT_OUT_DATA_IN,    // Output data.
	input wire logic [7:0] PERIPH_OUTPUT_IN,    // Peripheral outputs.
	input wire logic       STANDBY_IN,          // Standby.
	input wire logic [7:0] KEY_INPUT_MASK_IN,   // Key masks.
	input wire logic       INT_SOURCE_SEL7_IN,  // Source select 7.
	input wire logic       EXT_INT_7_ENABLE_IN, // Enable 7.
	input wire logic       INT_VECTOR_SEL_IN,   // Vector select.
	input wire logic       EXT_INT_6_ENABLE_IN, // Enable 6.
	input wire logic [7:0] PIN_OUT,             // Pin output levels.
	input wire logic [7:0] PIN_OE_OUT,          // Output enables.
	input wire logic [7:0] PULLUP_EN_OUT,       // Pull-ups.
	input wire logic [7:0] PORT_DATA_OUT,       // Conditioned data.
	input wire logic [7:0] KEY_INPUT_OUT,       // Key lines.
	input wire logic       EXT_INT_7_N_OUT,     // Interrupt 7.
	input wire logic       EXT_INT_6_N_OUT      // Interrupt 6.
);
	default clocking dc @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	pullup_gate_a: assert property ($past(RSTN_IN) |->
		(PULLUP_EN_OUT & $past(PIN_DIRECTION_IN | PERIPH_OUTPUT_IN | {8{STANDBY_IN}})) == 8'h00)
		else $error("Pull-up on for a pin that is not an input.");
	dir_oe_a: assert property ($past(RSTN_IN) |->
		PIN_OE_OUT == $past(PIN_DIRECTION_IN)) else $error("Output enable wrong.");
	out_level_a: assert property ($past(RSTN_IN) |->
		PIN_OUT == $past(PORT_OUT_DATA_IN & PIN_DIRECTION_IN)) else $error("Pin level wrong.");
	key_line7_a: assert property ($past(RSTN_IN) |-> KEY_INPUT_OUT[7] ==
		$past(PORT_DATA_OUT[7] | PIN_DIRECTION_IN[7] | KEY_INPUT_MASK_IN[7]))
		else $error("Key line 7 wrong.");
	key_line6_a: assert property ($past(RSTN_IN) |-> KEY_INPUT_OUT[6] ==
		$past(PORT_DATA_OUT[6] | PIN_DIRECTION_IN[6] | KEY_INPUT_MASK_IN[6]))
		else $error("Key line 6 wrong.");
	ext_int7_a: assert property ($past(RSTN_IN) |-> EXT_INT_7_N_OUT == $past(
		PORT_DATA_OUT[7] | PIN_DIRECTION_IN[7] | INT_SOURCE_SEL7_IN | !EXT_INT_7_ENABLE_IN))
		else $error("Interrupt 7 wrong.");
	ext_int6_a: assert property ($past(RSTN_IN) |-> EXT_INT_6_N_OUT == $past(
		PORT_DATA_OUT[6] | PIN_DIRECTION_IN[6] | INT_VECTOR_SEL_IN | !EXT_INT_6_ENABLE_IN))
		else $error("Interrupt 6 wrong.");
	data_source_a: assert property ($past(RSTN_IN) |->
		((PORT_DATA_OUT ^ $past(PORT_DATA_OUT)) & (PORT_DATA_OUT ^ $past(PIN_IN))) == 8'h00)
		else $error("Data took a level not seen on the pin.");
	resp_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
		S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("Write response dropped.");
	cover property (!EXT_INT_7_N_OUT);
	cover property (!EXT_INT_6_N_OUT && !KEY_INPUT_OUT[6]);
	cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h2);
endmodule
bind p6ic_top p6ic_props chk_u (.*);

//--- bench/test_port6_input_conditioning.sv
// Self-checking bench for the port 6 input conditioning block.
`timescale 1ns/1ps
module test_port6_input_conditioning;
	logic        clk = 1'h0, rstn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, stby = 1'h0, s7 = 1'h0, e7 = 1'h0;
	logic        vs = 1'h0, e6 = 1'h0, awready, wready, bvalid, arready, rvalid, ext_interrupt_7, ext_interrupt_6;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lvl = 8'h00, drv = 8'hff, dir = 8'h00;
	logic [7:0]  odat = 8'h00, peri = 8'h00, mask = 8'h00, pin, pout, oe, pu, data, key;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	logic [3:0]  strb = 4'hf;
	int          bad_count = 0, num_checks = 0, cyc = 0, seed = 32'habbc;
	always #5 clk = ~clk;
	p6ic_top #(.DIV_LOG2({5'h8, 5'h7, 5'h6, 5'h5, 5'h4, 5'h3, 5'h2, 5'h1})) dut_u (
		.CLOCK_IN(clk), .RSTN_IN(rstn), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
		.S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(strb),
		.S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
		.S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.PIN_IN(pin), .PIN_DIRECTION_IN(dir), .PORT_OUT_DATA_IN(odat), .PERIPH_OUTPUT_IN(peri),
		.STANDBY_IN(stby), .KEY_INPUT_MASK_IN(mask), .INT_SOURCE_SEL7_IN(s7),
		.EXT_INT_7_ENABLE_IN(e7), .INT_VECTOR_SEL_IN(vs), .EXT_INT_6_ENABLE_IN(e6),
		.PIN_OUT(pout), .PIN_OE_OUT(oe), .PULLUP_EN_OUT(pu), .PORT_DATA_OUT(data),
		.KEY_INPUT_OUT(key), .EXT_INT_7_N_OUT(ext_interrupt_7), .EXT_INT_6_N_OUT(ext_interrupt_6));
	p6ic_pad_model pad_u (.lvl_in(lvl), .drv_in(drv), .pout_in(pout), .oe_in(oe), .pu_in(pu),
		.clk_in(clk), .pad_out(pin));
	function automatic int per(input int c);
		return 2 << c;
	endfunction
	function automatic logic [7:0] pu_exp(input logic [7:0] c, d, pe, input logic s);
		return s ? 8'h00 : c & ~d & ~pe;
	endfunction
	task automatic end_sim;
		$display("Checks %0d, errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Handshakes are judged at the negative edge, where the ready seen equals the next edge's.
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] rp);
		bit ah, wh, eh;
		eh = 1'b0;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		while (!eh) begin
			@(negedge clk);
			ah = wr ? awready & awvalid : arready & arvalid;
			wh = wready & wvalid;
			eh = wr ? bvalid : rvalid;
			q = rdata;
			rp = wr ? bresp : rresp;
			@(posedge clk);
			if (ah) begin
				awvalid <= 1'h0;
				arvalid <= 1'h0;
			end
			if (wh) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		rready <= 1'h0;
		// One idle edge keeps the next call from raising a ready in the same step.
		@(posedge clk);
	endtask
	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b1, a, d, q, r);
		chk(32'(r), 32'(e));
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b0, a, 32'h0, q, r);
		chk(q, d);
		chk(32'(r), 32'(e));
	endtask
	// Glitches to the expected level one clock short of a period are rejected; held levels land within two periods.
	task automatic filt(input int c);
		int p, n;
		p = per(c);
		wchk(p6ic_pkg::OFF_NC_CYCLE, c, p6ic_pkg::RESP_OKAY);
		lvl <= 8'h00;
		repeat (4 * p + 8) @(posedge clk);
		lvl <= 8'hff;
		repeat (p - 1) @(posedge clk);
		lvl <= 8'h00;
		repeat (2 * p + 4) @(posedge clk);
		@(negedge clk);
		chk(data, 8'h00);
		@(posedge clk);
		lvl <= 8'hff;
		n = 0;
		while (data[0] !== 1'h1 && n < 4 * p) begin
			@(posedge clk);
			n++;
			@(negedge clk);
		end
		chk(32'(n >= p + 1 && n <= 2 * p + 4), 32'h1);
		@(posedge clk);
		lvl <= 8'h0f;
		repeat (p - 1) @(posedge clk);
		lvl <= 8'hff;
		repeat (2 * p + 4) @(posedge clk);
		rchk(p6ic_pkg::OFF_PIN_STATE, 32'hff, p6ic_pkg::RESP_OKAY);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("Error at %0t: timeout", $time);
			end_sim;
		end
	end
	initial begin
		logic [31:0] v;
		logic [7:0]  p, d, x;
		repeat (2) @(posedge clk);
		chk(pu, 8'h00);
		rstn <= 1'h1;
		@(posedge clk);
		for (int i = 0; i < 4; i++) begin
			rchk(8'(4 * i), 32'h0, p6ic_pkg::RESP_OKAY);
		end
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & (i == 3 ? 32'h7 : 32'hff);
			wchk(8'(4 * i), v, p6ic_pkg::RESP_OKAY);
			rchk(8'(4 * i), v, p6ic_pkg::RESP_OKAY);
		end
		wchk(8'h14, v, p6ic_pkg::RESP_SLVERR);
		rchk(8'h14, p6ic_pkg::READ_UNMAPPED, p6ic_pkg::RESP_SLVERR);
		wchk(p6ic_pkg::OFF_PIN_STATE, v, p6ic_pkg::RESP_SLVERR);
		// A write without the lane 0 strobe must leave the register untouched.
		strb <= 4'he;
		wchk(p6ic_pkg::OFF_NC_CYCLE, ~v & 32'h7, p6ic_pkg::RESP_OKAY);
		strb <= 4'hf;
		rchk(p6ic_pkg::OFF_NC_CYCLE, v, p6ic_pkg::RESP_OKAY);
		p = 8'($random(seed));
		wchk(p6ic_pkg::OFF_PULLUP, p, p6ic_pkg::RESP_OKAY);
		wchk(p6ic_pkg::OFF_NC_ENABLE, 32'h0, p6ic_pkg::RESP_OKAY);
		for (int i = 0; i < 12; i++) begin
			v = $random(seed);
			d = i < 6 ? 8'h00 : v[7:0];
			dir <= d;
			drv <= ~d;
			peri <= v[15:8];
			odat <= v[15:8];
			mask <= v[23:16];
			lvl <= v[31:24];
			{stby, s7, e7, vs, e6} <= i < 3 ? 5'h05 : v[12:8];
			repeat (3) @(posedge clk);
			@(negedge clk);
			x = (v[31:24] & ~d) | (v[15:8] & d);
			chk(data, x);
			chk(pu, pu_exp(p, d, v[15:8], stby));
			chk(oe, d);
			chk(key, x | d | v[23:16]);
			chk(ext_interrupt_7, x[7] | d[7] | s7 | !e7);
			chk(ext_interrupt_6, x[6] | d[6] | vs | !e6);
			@(posedge clk);
		end
		dir <= 8'h00;
		drv <= 8'hff;
		wchk(p6ic_pkg::OFF_NC_POLAR, 32'h0f, p6ic_pkg::RESP_OKAY);
		wchk(p6ic_pkg::OFF_NC_ENABLE, 32'hff, p6ic_pkg::RESP_OKAY);
		for (int c = 0; c < 8; c++) begin
			filt(c);
		end
		end_sim;
	end
endmodule

//--- hdl/p6ic_noise_filter.sv
// Per-pin noise canceller with a selectable expected level.
`timescale 1ns/1ps
module p6ic_noise_filter #(
	parameter int unsigned   WIDTH = 8
) (
	input  wire logic             clk_in,     // System clock.
	input  wire logic             rstn_in,    // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] pin_in,     // Raw pin levels.
	input  wire logic [WIDTH-1:0] enable_in,  // Filter enable per pin.
	input  wire logic [WIDTH-1:0] polar_in,   // Expected level per pin.
	input  wire logic             sample_in,  // Sample enable pulse.
	output logic      [WIDTH-1:0] data_out    // Conditioned pin data.
);

	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] data;
	} p6ic_flt_state_t;

	p6ic_flt_state_t state_q;
	p6ic_flt_state_t state_d;

	always_comb begin
		state_d = state_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (!enable_in[i]) begin
				state_d.prev[i] = pin_in[i]; // [RULE3]
				state_d.data[i] = pin_in[i]; // [RULE3]
			end else if (sample_in) begin
				state_d.prev[i] = pin_in[i]; // [RULE7]
				// The expected level needs two agreeing samples; the other level passes on one.
				if ((pin_in[i] != polar_in[i]) || (state_q.prev[i] == pin_in[i])) begin // [RULE4] [RULE5] [RULE6] [RULE7]
					state_d.data[i] = pin_in[i];
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign data_out = state_q.data;

endmodule

//--- hdl/p6ic_pkg.sv
// Shared constants for the port 6 input conditioning block.
package p6ic_pkg;

	localparam logic [7:0]  OFF_PULLUP     = 8'h00;
	localparam logic [7:0]  OFF_NC_ENABLE  = 8'h04;
	localparam logic [7:0]  OFF_NC_POLAR   = 8'h08;
	localparam logic [7:0]  OFF_NC_CYCLE   = 8'h0c;
	localparam logic [7:0]  OFF_PIN_STATE  = 8'h10;

	localparam logic [7:0]  RST_PULLUP     = 8'h00;
	localparam logic [7:0]  RST_NC_ENABLE  = 8'h00;
	localparam logic [7:0]  RST_NC_POLAR   = 8'h00;
	localparam logic [2:0]  RST_NC_CYCLE   = 3'h0;

	localparam int unsigned CYCLE_W        = 3;
	localparam int unsigned DIV_CNT_W      = 18;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

endpackage

//--- hdl/p6ic_sample_div.sv
// Shared sampling-period divider producing a one-cycle sample enable.
`timescale 1ns/1ps
module p6ic_sample_div #(
	parameter int unsigned       CNT_W    = 18,
	parameter logic [7:0][4:0]   DIV_LOG2 = {5'd18, 5'd17, 5'd16, 5'd15,
	                                          5'd14, 5'd13, 5'd5, 5'd1}
) (
	input  wire logic            clk_in,       // System clock.
	input  wire logic            rstn_in,      // Asynchronous reset, active low.
	input  wire logic [2:0]      code_in,      // Sampling period code.
	output logic                 sample_en_out // One-cycle sample pulse.
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             pulse;
	} p6ic_div_state_t;

	p6ic_div_state_t state_q;
	p6ic_div_state_t state_d;
	logic [CNT_W-1:0] mask;

	// The low bits of a free-running count all at one mark one period of 2^n clocks.
	always_comb begin
		mask          = ({{(CNT_W-1){1'b0}}, 1'b1} << DIV_LOG2[code_in]) - 1'b1; // [RULE8]
		state_d       = state_q;
		state_d.cnt   = state_q.cnt + 1'b1;
		state_d.pulse = ((state_q.cnt & mask) == mask); // [RULE8]
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sample_en_out = state_q.pulse;

endmodule

//--- hdl/p6ic_top.sv
// Port 6 input conditioning top: AXI4-Lite registers, pull-ups, filters, pin routing.
//
// Overview of operation
// RULE1: Pull-up on when input and control bit set.
// RULE2: Pull-up off in reset, standby, peripheral output.
// RULE3: Per-pin filter enable; disabled pins pass directly.
// RULE4: High expected: store 1 only when stable.
// RULE5: Low expected: store 0 only when stable.
// RULE6: Polarity bit 1 expects high, reset 0.
// RULE7: Stable means consecutive samples agree.
// RULE8: Period code selects clock divided 2..262144.
// RULE9: Cycle register bits 7..3 reserved, write zero.
// RULE10: Pin 7 direction selects input or output.
// RULE11: Pin 7 feeds key line 7 when unmasked.
// RULE12: Pin 7 is interrupt 7 when selected, enabled.
// RULE13: Pin 6 direction selects input or output.
// RULE14: Pin 6 feeds key line 6 when unmasked.
// RULE15: Pin 6 is interrupt 6 when selected, enabled.
`timescale 1ns/1ps
module p6ic_top #(
	parameter int unsigned       ADDR_W   = 8,
	parameter int unsigned       PINS     = 8,
	parameter logic [7:0][4:0]   DIV_LOG2 = {5'd18, 5'd17, 5'd16, 5'd15,
	                                          5'd14, 5'd13, 5'd5, 5'd1}
) (
	input  wire logic              CLOCK_IN,           // System clock, 100 MHz.
	input  wire logic              RSTN_IN,            // Asynchronous reset, active low.
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,    // Write address.
	input  wire logic              S_AXI_AWVALID_IN,   // Write address valid.
	output logic                   S_AXI_AWREADY_OUT,  // Write address ready.
	input  wire logic [31:0]       S_AXI_WDATA_IN,     // Write data.
	input  wire logic [3:0]        S_AXI_WSTRB_IN,     // Write byte strobes.
	input  wire logic              S_AXI_WVALID_IN,    // Write data valid.
	output logic                   S_AXI_WREADY_OUT,   // Write data ready.
	output logic [1:0]             S_AXI_BRESP_OUT,    // Write response.
	output logic                   S_AXI_BVALID_OUT,   // Write response valid.
	input  wire logic              S_AXI_BREADY_IN,    // Write response ready.
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,    // Read address.
	input  wire logic              S_AXI_ARVALID_IN,   // Read address valid.
	output logic                   S_AXI_ARREADY_OUT,  // Read address ready.
	output logic [31:0]            S_AXI_RDATA_OUT,    // Read data.
	output logic [1:0]             S_AXI_RRESP_OUT,    // Read response.
	output logic                   S_AXI_RVALID_OUT,   // Read data valid.
	input  wire logic              S_AXI_RREADY_IN,    // Read data ready.
	input  wire logic [PINS-1:0]   PIN_IN,             // Pin input levels.
	input  wire logic [PINS-1:0]   PIN_DIRECTION_IN,   // Direction bits, 1 is output.
	input  wire logic [PINS-1:0]   PORT_OUT_DATA_IN,   // Output data for general outputs.
	input  wire logic [PINS-1:0]   PERIPH_OUTPUT_IN,   // Pin used as peripheral output.
	input  wire logic              STANDBY_IN,         // Software standby mode.
	input  wire logic [PINS-1:0]   KEY_INPUT_MASK_IN,  // Key-input mask bits, 1 masks.
	input  wire logic              INT_SOURCE_SEL7_IN, // Interrupt 7 source select.
	input  wire logic              EXT_INT_7_ENABLE_IN,// Interrupt 7 enable.
	input  wire logic              INT_VECTOR_SEL_IN,  // Interrupt vector select.
	input  wire logic              EXT_INT_6_ENABLE_IN,// Interrupt 6 enable.
	output logic [PINS-1:0]        PIN_OUT,            // Pin output levels.
	output logic [PINS-1:0]        PIN_OE_OUT,         // Pin output enables.
	output logic [PINS-1:0]        PULLUP_EN_OUT,      // Pull-up switch per pin.
	output logic [PINS-1:0]        PORT_DATA_OUT,      // Conditioned input data.
	output logic [PINS-1:0]        KEY_INPUT_OUT,      // Key-input lines, active low.
	output logic                   EXT_INT_7_N_OUT,    // External interrupt 7, active low.
	output logic                   EXT_INT_6_N_OUT     // External interrupt 6, active low.
);

	localparam int unsigned CW = p6ic_pkg::CYCLE_W;

	typedef struct packed {
		logic [PINS-1:0]   pullup_ctl;
		logic [PINS-1:0]   nc_enable;
		logic [PINS-1:0]   nc_polar;
		logic [CW-1:0]     nc_cycle;
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [PINS-1:0]   pullup_en;
		logic [PINS-1:0]   pin_out;
		logic [PINS-1:0]   pin_oe;
		logic [PINS-1:0]   key_line;
		logic              ext_interrupt_7_n;
		logic              ext_interrupt_6_n;
	} p6ic_state_t;

	p6ic_state_t state_q;
	p6ic_state_t state_d;

	logic            sample_en;
	logic [PINS-1:0] port_data;
	logic            aw_take;
	logic            w_take;
	logic            ar_take;
	logic [7:0]      wr_off;
	logic [7:0]      rd_off;

	// Byte lane 0 carries every register; the upper lanes are ignored.
	function automatic logic [PINS-1:0] lane0(input logic [PINS-1:0] old_v,
	                                          input logic [31:0]     data_v,
	                                          input logic [3:0]      strb_v);
		logic [PINS-1:0] res;
		res = strb_v[0] ? data_v[PINS-1:0] : old_v;
		return res;
	endfunction

	function automatic logic [7:0] word_off(input logic [ADDR_W-1:0] addr_v);
		logic [7:0] res;
		res = 8'({addr_v[ADDR_W-1:2], 2'h0});
		return res;
	endfunction

	p6ic_sample_div #(
		.CNT_W    (p6ic_pkg::DIV_CNT_W),
		.DIV_LOG2 (DIV_LOG2)
	) u_div (
		.clk_in        (CLOCK_IN),
		.rstn_in       (RSTN_IN),
		.code_in       (state_q.nc_cycle),
		.sample_en_out (sample_en)
	);

	p6ic_noise_filter #(
		.WIDTH (PINS)
	) u_filter (
		.clk_in    (CLOCK_IN),
		.rstn_in   (RSTN_IN),
		.pin_in    (PIN_IN),
		.enable_in (state_q.nc_enable),
		.polar_in  (state_q.nc_polar),
		.sample_in (sample_en),
		.data_out  (port_data)
	);

	assign aw_take = S_AXI_AWVALID_IN && !state_q.aw_have && !state_q.bvalid;
	assign w_take  = S_AXI_WVALID_IN && !state_q.w_have && !state_q.bvalid;
	assign ar_take = S_AXI_ARVALID_IN && !state_q.rvalid;
	assign wr_off  = word_off(state_q.aw_addr);
	assign rd_off  = word_off(S_AXI_ARADDR_IN);

	always_comb begin
		state_d = state_q;

		// Write address and data are captured independently, in either order.
		if (aw_take) begin
			state_d.aw_have = 1'b1;
			state_d.aw_addr = S_AXI_AWADDR_IN;
		end
		if (w_take) begin
			state_d.w_have = 1'b1;
			state_d.w_data = S_AXI_WDATA_IN;
			state_d.w_strb = S_AXI_WSTRB_IN;
		end

		if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
			state_d.aw_have = 1'b0;
			state_d.w_have  = 1'b0;
			state_d.bvalid  = 1'b1;
			state_d.bresp   = p6ic_pkg::RESP_OKAY;
			case (wr_off)
				p6ic_pkg::OFF_PULLUP: begin
					state_d.pullup_ctl = lane0(state_q.pullup_ctl, state_q.w_data,
					                           state_q.w_strb);
				end
				p6ic_pkg::OFF_NC_ENABLE: begin
					state_d.nc_enable = lane0(state_q.nc_enable, state_q.w_data,
					                          state_q.w_strb); // [RULE3]
				end
				p6ic_pkg::OFF_NC_POLAR: begin
					state_d.nc_polar = lane0(state_q.nc_polar, state_q.w_data,
					                         state_q.w_strb); // [RULE6]
				end
				p6ic_pkg::OFF_NC_CYCLE: begin
					// Only the period code is stored; the upper bits are not kept.
					if (state_q.w_strb[0]) begin
						state_d.nc_cycle = state_q.w_data[CW-1:0]; // [RULE8] [RULE9]
					end
				end
				p6ic_pkg::OFF_PIN_STATE: begin
					state_d.bresp = p6ic_pkg::RESP_SLVERR;
				end
				default: begin
					state_d.bresp = p6ic_pkg::RESP_SLVERR;
				end
			endcase
		end else if (state_q.bvalid && S_AXI_BREADY_IN) begin
			state_d.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken.
		if (ar_take) begin
			state_d.rvalid = 1'b1;
			state_d.rresp  = p6ic_pkg::RESP_OKAY;
			state_d.rdata  = p6ic_pkg::READ_UNMAPPED;
			case (rd_off)
				p6ic_pkg::OFF_PULLUP: begin
					state_d.rdata[PINS-1:0] = state_q.pullup_ctl;
				end
				p6ic_pkg::OFF_NC_ENABLE: begin
					state_d.rdata[PINS-1:0] = state_q.nc_enable;
				end
				p6ic_pkg::OFF_NC_POLAR: begin
					state_d.rdata[PINS-1:0] = state_q.nc_polar;
				end
				p6ic_pkg::OFF_NC_CYCLE: begin
					state_d.rdata[CW-1:0] = state_q.nc_cycle; // [RULE9]
				end
				p6ic_pkg::OFF_PIN_STATE: begin
					state_d.rdata[PINS-1:0] = port_data;
				end
				default: begin
					state_d.rresp = p6ic_pkg::RESP_SLVERR;
				end
			endcase
		end else if (state_q.rvalid && S_AXI_RREADY_IN) begin
			state_d.rvalid = 1'b0;
		end

		// Pull-ups act only on input pins and never in standby or as peripheral outputs.
		for (int i = 0; i < PINS; i++) begin
			state_d.pullup_en[i] = state_q.pullup_ctl[i] && !PIN_DIRECTION_IN[i] &&
			                       !STANDBY_IN && !PERIPH_OUTPUT_IN[i]; // [RULE1] [RULE2]
		end

		// General output drive follows the direction bits.
		state_d.pin_oe  = PIN_DIRECTION_IN; // [RULE10] [RULE13]
		state_d.pin_out = PORT_OUT_DATA_IN & PIN_DIRECTION_IN; // [RULE10] [RULE13]

		// Key-input lines idle high unless the pin is an unmasked input.
		for (int i = 0; i < PINS; i++) begin
			if (!PIN_DIRECTION_IN[i] && !KEY_INPUT_MASK_IN[i]) begin
				state_d.key_line[i] = port_data[i]; // [RULE11] [RULE14]
			end else begin
				state_d.key_line[i] = 1'b1;
			end
		end

		if (!PIN_DIRECTION_IN[7] && !INT_SOURCE_SEL7_IN && EXT_INT_7_ENABLE_IN) begin
			state_d.ext_interrupt_7_n = port_data[7]; // [RULE12]
		end else begin
			state_d.ext_interrupt_7_n = 1'b1;
		end

		if (!PIN_DIRECTION_IN[6] && !INT_VECTOR_SEL_IN && EXT_INT_6_ENABLE_IN) begin
			state_d.ext_interrupt_6_n = port_data[6]; // [RULE15]
		end else begin
			state_d.ext_interrupt_6_n = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_q            <= '0;
			state_q.pullup_ctl <= p6ic_pkg::RST_PULLUP;
			state_q.nc_enable  <= p6ic_pkg::RST_NC_ENABLE;
			state_q.nc_polar   <= p6ic_pkg::RST_NC_POLAR; // [RULE6]
			state_q.nc_cycle   <= p6ic_pkg::RST_NC_CYCLE;
			state_q.pullup_en  <= '0; // [RULE2]
			state_q.key_line   <= '1;
			state_q.ext_interrupt_7_n     <= 1'b1;
			state_q.ext_interrupt_6_n     <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	assign S_AXI_AWREADY_OUT = !state_q.aw_have && !state_q.bvalid;
	assign S_AXI_WREADY_OUT  = !state_q.w_have && !state_q.bvalid;
	assign S_AXI_BVALID_OUT  = state_q.bvalid;
	assign S_AXI_BRESP_OUT   = state_q.bresp;
	assign S_AXI_ARREADY_OUT = !state_q.rvalid;
	assign S_AXI_RVALID_OUT  = state_q.rvalid;
	assign S_AXI_RDATA_OUT   = state_q.rdata;
	assign S_AXI_RRESP_OUT   = state_q.rresp;
	assign PIN_OUT           = state_q.pin_out;
	assign PIN_OE_OUT        = state_q.pin_oe;
	assign PULLUP_EN_OUT     = state_q.pullup_en;
	assign PORT_DATA_OUT     = port_data;
	assign KEY_INPUT_OUT     = state_q.key_line;
	assign EXT_INT_7_N_OUT   = state_q.ext_interrupt_7_n;
	assign EXT_INT_6_N_OUT   = state_q.ext_interrupt_6_n;

endmodule
